/* hw/diag_pkg.sv */
// Constants, register map and types of the output test-pattern block
// How it works
// (RQ1) First programmable word: low byte at 8Dh, high byte at 8Eh.
// (RQ2) Second programmable word: low byte at 8Fh, high byte at 90h; alternating mode only.
// (RQ3) Selector bits 7-4: 0 normal, 1 zeros, 2 ones, 3 toggle, 4 ramp.
// (RQ4) Code 6 sends first word steadily; code 7 alternates first and second words.
// (RQ5) Code 8 sends deskew word 0xAAAA; unlisted codes are not to be used.
// (RQ6) Enable bits 3..0 for channels D..A substitute the pattern when set.
// (RQ7) Software writes zero to unused upper bits and reads zero back.
// (RQ8) Bits 3-0 at ADh select down-conversion mode of pair AB.
// (RQ9) Every register of the block resets to zero; no pattern after reset.
// (RQ10) Software sets the digital page select bit before touching these registers.
// (RQ11) Alternating mode switches words on each successive output sample.
package diag_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_PAGE_SEL  = 8'h12;
   localparam logic [7:0] ADDR_WORD1_LO  = 8'h8D;
   localparam logic [7:0] ADDR_WORD1_HI  = 8'h8E;
   localparam logic [7:0] ADDR_WORD2_LO  = 8'h8F;
   localparam logic [7:0] ADDR_WORD2_HI  = 8'h90;
   localparam logic [7:0] ADDR_SEL_ENA   = 8'h91;
   localparam logic [7:0] ADDR_SPECIAL_A = 8'hAB;
   localparam logic [7:0] ADDR_SPECIAL_B = 8'hAC;
   localparam logic [7:0] ADDR_DDC_AB    = 8'hAD;
   // Field positions and reset value
   localparam int unsigned SEL_LSB   = 4;
   localparam int unsigned SEL_MSB   = 7;
   localparam int unsigned ENA_MSB   = 3;
   localparam int unsigned PAGE_BIT  = 0;
   localparam int unsigned SPEC_BIT  = 0;
   localparam int unsigned DDC_MSB   = 3;
   localparam logic [7:0]  REG_RESET = 8'h00;
   // Selector codes
   localparam logic [3:0] PAT_NORMAL = 4'h0;
   localparam logic [3:0] PAT_ZEROS  = 4'h1;
   localparam logic [3:0] PAT_ONES   = 4'h2;
   localparam logic [3:0] PAT_TOGGLE = 4'h3;
   localparam logic [3:0] PAT_RAMP   = 4'h4;
   localparam logic [3:0] PAT_WORD1  = 4'h6;
   localparam logic [3:0] PAT_ALT    = 4'h7;
   localparam logic [3:0] PAT_DESKEW = 4'h8;
   // Fixed pattern words
   localparam logic [15:0] WORD_ZERO   = 16'h0000;
   localparam logic [15:0] WORD_ONES   = 16'hFFFF;
   localparam logic [15:0] WORD_TOG_A  = 16'h5555;
   localparam logic [15:0] WORD_DESKEW = 16'hAAAA;
   localparam logic [15:0] RAMP_STEP   = 16'h0001;
   // Serial frame: 16 header bits then 8 data bits
   localparam logic [4:0] HDR_LAST   = 5'h0F;
   localparam logic [4:0] FRAME_LAST = 5'h17;
   localparam logic [4:0] DATA_FIRST = 5'h10;
   typedef enum logic [1:0] {SPI_IDLE, SPI_HEADER, SPI_DATA, SPI_DONE} spi_state_t;
endpackage

/* hw/sample_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
module sample_fifo #(
   parameter int unsigned WIDTH = 64,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             i_sys_clk,
   input  wire logic             i_rst,
   input  wire logic             i_wr_valid,
   output logic                  o_wr_ready,
   input  wire logic [WIDTH-1:0] i_wr_data,
   output logic                  o_rd_valid,
   input  wire logic             i_rd_ready,
   output logic      [WIDTH-1:0] o_rd_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic             push;
   logic             pop;

   // Full when pointers differ only in the wrap bit
   assign o_wr_ready = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
   assign o_rd_valid = (wr_ptr != rd_ptr);
   assign o_rd_data  = mem[rd_ptr[AW-1:0]];
   assign push       = i_wr_valid && o_wr_ready;
   assign pop        = o_rd_valid && i_rd_ready;

   // Storage has no reset; only pointers define content
   always_ff @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_wr_data;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

/* hw/pattern_mux.sv */
// One channel's choice between live sample and test pattern
module pattern_mux #(
   parameter int unsigned W = 16
) (
   input  wire logic         i_enable,
   input  wire logic [3:0]   i_sel,
   input  wire logic [W-1:0] i_sample,
   input  wire logic [W-1:0] i_word_one,
   input  wire logic [W-1:0] i_word_two,
   input  wire logic [W-1:0] i_ramp,
   input  wire logic         i_phase,
   output logic      [W-1:0] o_data
);
   import diag_pkg::*;
   // Unlisted codes fall back to live data so a bad write stays harmless
   always_comb begin
      o_data = i_sample;
      if (i_enable) begin // see (RQ6)
         case (i_sel)
            PAT_NORMAL: o_data = i_sample; // see (RQ3)
            PAT_ZEROS:  o_data = W'(WORD_ZERO);
            PAT_ONES:   o_data = W'(WORD_ONES);
            PAT_TOGGLE: o_data = i_phase ? W'(WORD_DESKEW) : W'(WORD_TOG_A);
            PAT_RAMP:   o_data = i_ramp;
            PAT_WORD1:  o_data = i_word_one; // see (RQ4)
            PAT_ALT:    o_data = i_phase ? i_word_two : i_word_one; // see (RQ2) (RQ11)
            PAT_DESKEW: o_data = W'(WORD_DESKEW); // see (RQ5)
            default:    o_data = i_sample;
         endcase
      end
   end
endmodule

/* hw/output_test_pattern_control.sv */
// Test-pattern register bank with serial config port and sample path
module output_test_pattern_control #(
   parameter int unsigned SAMPLE_W   = 16,
   parameter int unsigned FIFO_DEPTH = 16
) (
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   input  wire logic                i_spi_sclk,
   input  wire logic                i_spi_sen_n,
   input  wire logic                i_spi_sdio,
   output logic                     o_spi_sdio,
   output logic                     o_spi_sdio_oe_n,
   input  wire logic                i_in_valid,
   output logic                     o_in_ready,
   input  wire logic [SAMPLE_W-1:0] i_in_ch_a,
   input  wire logic [SAMPLE_W-1:0] i_in_ch_b,
   input  wire logic [SAMPLE_W-1:0] i_in_ch_c,
   input  wire logic [SAMPLE_W-1:0] i_in_ch_d,
   output logic                     o_out_valid,
   input  wire logic                i_out_ready,
   output logic      [SAMPLE_W-1:0] o_out_ch_a,
   output logic      [SAMPLE_W-1:0] o_out_ch_b,
   output logic      [SAMPLE_W-1:0] o_out_ch_c,
   output logic      [SAMPLE_W-1:0] o_out_ch_d,
   output logic                     o_digital_page_select,
   output logic                     o_mandatory_set_bit_a,
   output logic                     o_mandatory_set_bit_b,
   output logic      [diag_pkg::DDC_MSB:0] o_downconv_setting_pair_ab
);
   import diag_pkg::*;

   localparam int unsigned NCH = 4;
   localparam int unsigned FW  = NCH * SAMPLE_W;

   // Pin synchronisers
   logic sclk_meta;
   logic sclk_sync;
   logic sclk_prev;
   logic sen_meta;
   logic sen_sync;
   logic sdio_meta;
   logic sdio_sync;
   logic sclk_rise;
   logic sclk_fall;

   // Serial frame state
   spi_state_t state;
   logic [4:0] bit_cnt;
   logic [14:0] shreg;
   logic       hdr_rw;
   logic [7:0] hdr_addr;
   logic       load_rd;
   logic [7:0] rd_shift;
   logic       wr_stb;
   logic [7:0] wr_data;
   logic       acc_ok;

   // Register contents
   logic [7:0] word_one_lo;
   logic [7:0] word_one_hi;
   logic [7:0] word_two_lo;
   logic [7:0] word_two_hi;
   logic [SEL_MSB-SEL_LSB:0] diag_output_choice;
   logic [ENA_MSB:0] diag_enable;
   logic       page_sel;
   logic       special_a;
   logic       special_b;
   logic [DDC_MSB:0] ddc_ab;

   // Sample path
   logic          fifo_valid;
   logic          fifo_ready;
   logic [FW-1:0] fifo_data;
   logic [FW-1:0] in_word;
   logic [FW-1:0] pat_word;
   logic          load_out;
   logic [SAMPLE_W-1:0] ramp;
   logic          phase;
   logic          restart;

   // Only the second stage is read; edge detect uses second and third
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         sclk_meta <= 1'b0;
         sclk_sync <= 1'b0;
         sclk_prev <= 1'b0;
         sen_meta  <= 1'b1;
         sen_sync  <= 1'b1;
         sdio_meta <= 1'b0;
         sdio_sync <= 1'b0;
      end else begin
         sclk_meta <= i_spi_sclk;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         sen_meta  <= i_spi_sen_n;
         sen_sync  <= sen_meta;
         sdio_meta <= i_spi_sdio;
         sdio_sync <= sdio_meta;
      end
   end

   assign sclk_rise = sclk_sync && !sclk_prev;
   assign sclk_fall = !sclk_sync && sclk_prev;

   // Page gate: the global page register always answers, block registers only when enabled
   always_comb begin
      acc_ok = 1'b0;
      if (hdr_addr == ADDR_PAGE_SEL) begin
         acc_ok = 1'b1;
      end else if (page_sel) begin // see (RQ10)
         case (hdr_addr)
            ADDR_WORD1_LO, ADDR_WORD1_HI, ADDR_WORD2_LO, ADDR_WORD2_HI,
            ADDR_SEL_ENA, ADDR_SPECIAL_A, ADDR_SPECIAL_B, ADDR_DDC_AB: acc_ok = 1'b1;
            default: acc_ok = 1'b0;
         endcase
      end
   end

   // Frame sequencer; raising the enable aborts a frame without a write
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state    <= SPI_IDLE;
         bit_cnt  <= 5'h00;
         shreg    <= 15'h0000;
         hdr_rw   <= 1'b0;
         hdr_addr <= 8'h00;
         load_rd  <= 1'b0;
         wr_stb   <= 1'b0;
         wr_data  <= 8'h00;
      end else begin
         load_rd <= 1'b0;
         wr_stb  <= 1'b0;
         if (sen_sync) begin
            state   <= SPI_IDLE;
            bit_cnt <= 5'h00;
         end else begin
            case (state)
               SPI_IDLE: begin
                  state   <= SPI_HEADER;
                  bit_cnt <= 5'h00;
               end
               SPI_HEADER: begin
                  if (sclk_rise) begin
                     shreg   <= {shreg[13:0], sdio_sync};
                     bit_cnt <= bit_cnt + 5'h01;
                     if (bit_cnt == HDR_LAST) begin
                        hdr_rw   <= shreg[14];
                        hdr_addr <= {shreg[6:0], sdio_sync};
                        load_rd  <= 1'b1;
                        state    <= SPI_DATA;
                     end
                  end
               end
               SPI_DATA: begin
                  if (sclk_rise) begin
                     shreg   <= {shreg[13:0], sdio_sync};
                     bit_cnt <= bit_cnt + 5'h01;
                     if (bit_cnt == FRAME_LAST) begin
                        wr_data <= {shreg[6:0], sdio_sync};
                        wr_stb  <= !hdr_rw && acc_ok;
                        state   <= SPI_DONE;
                     end
                  end
               end
               SPI_DONE: state <= SPI_DONE;
               default:  state <= SPI_IDLE;
            endcase
         end
      end
   end

   // Read-back mux; unused upper bits and unmapped addresses read zero
   function automatic logic [7:0] read_value(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         ADDR_PAGE_SEL:  v[PAGE_BIT] = page_sel;
         ADDR_WORD1_LO:  v = word_one_lo;
         ADDR_WORD1_HI:  v = word_one_hi;
         ADDR_WORD2_LO:  v = word_two_lo;
         ADDR_WORD2_HI:  v = word_two_hi;
         ADDR_SEL_ENA:   v = {diag_output_choice, diag_enable};
         ADDR_SPECIAL_A: v[SPEC_BIT] = special_a; // see (RQ7)
         ADDR_SPECIAL_B: v[SPEC_BIT] = special_b;
         ADDR_DDC_AB:    v[DDC_MSB:0] = ddc_ab;
         default:        v = 8'h00;
      endcase
      return v;
   endfunction

   // Read data leaves MSB first, changing on falling clock edges
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         rd_shift   <= 8'h00;
         o_spi_sdio <= 1'b0;
      end else if (load_rd) begin
         rd_shift   <= acc_ok ? read_value(hdr_addr) : 8'h00; // see (RQ10)
         o_spi_sdio <= acc_ok ? read_value(hdr_addr) >> 7 == 8'h01 : 1'b0;
      end else if (sclk_fall && state == SPI_DATA && bit_cnt > DATA_FIRST) begin
         rd_shift   <= {rd_shift[6:0], 1'b0};
         o_spi_sdio <= rd_shift[6];
      end
   end

   // Drive the data line from the end of a read header until the enable rises
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_spi_sdio_oe_n <= 1'b1;
      end else if (sen_sync) begin
         o_spi_sdio_oe_n <= 1'b1;
      end else if (load_rd) begin
         o_spi_sdio_oe_n <= !hdr_rw;
      end
   end

   // Page select lives in the global page and is always writable
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         page_sel <= 1'b0; // see (RQ9)
      end else if (wr_stb && hdr_addr == ADDR_PAGE_SEL) begin
         page_sel <= wr_data[PAGE_BIT];
      end
   end

   // Programmable pattern words
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         word_one_lo <= REG_RESET; // see (RQ9)
         word_one_hi <= REG_RESET;
         word_two_lo <= REG_RESET;
         word_two_hi <= REG_RESET;
      end else if (wr_stb) begin
         case (hdr_addr)
            ADDR_WORD1_LO: word_one_lo <= wr_data; // see (RQ1)
            ADDR_WORD1_HI: word_one_hi <= wr_data;
            ADDR_WORD2_LO: word_two_lo <= wr_data; // see (RQ2)
            ADDR_WORD2_HI: word_two_hi <= wr_data;
            default: ;
         endcase
      end
   end

   // Selector and channel enables
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         diag_output_choice <= REG_RESET[SEL_MSB:SEL_LSB]; // see (RQ9)
         diag_enable        <= REG_RESET[ENA_MSB:0];
      end else if (wr_stb && hdr_addr == ADDR_SEL_ENA) begin
         diag_output_choice <= wr_data[SEL_MSB:SEL_LSB]; // see (RQ3)
         diag_enable        <= wr_data[ENA_MSB:0]; // see (RQ6)
      end
   end

   // Special-mode bits and down-conversion mode; upper bits are not stored
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         special_a <= 1'b0; // see (RQ9)
         special_b <= 1'b0;
         ddc_ab    <= REG_RESET[DDC_MSB:0];
      end else if (wr_stb) begin
         case (hdr_addr)
            ADDR_SPECIAL_A: special_a <= wr_data[SPEC_BIT];
            ADDR_SPECIAL_B: special_b <= wr_data[SPEC_BIT];
            ADDR_DDC_AB:    ddc_ab    <= wr_data[DDC_MSB:0]; // see (RQ8)
            default: ;
         endcase
      end
   end

   assign o_digital_page_select      = page_sel;
   assign o_mandatory_set_bit_a      = special_a;
   assign o_mandatory_set_bit_b      = special_b;
   assign o_downconv_setting_pair_ab = ddc_ab;

   // Channel A in the low lane of the FIFO word
   assign in_word = {i_in_ch_d, i_in_ch_c, i_in_ch_b, i_in_ch_a};

   // Buffer absorbs output stalls; its ready back-pressures the source
   sample_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_wr_valid (i_in_valid),
      .o_wr_ready (o_in_ready),
      .i_wr_data  (in_word),
      .o_rd_valid (fifo_valid),
      .i_rd_ready (fifo_ready),
      .o_rd_data  (fifo_data)
   );

   assign fifo_ready = !o_out_valid || i_out_ready;
   assign load_out   = fifo_valid && fifo_ready;
   assign restart    = wr_stb && hdr_addr == ADDR_SEL_ENA;

   // Ramp and alternation advance per emitted sample; a selector write restarts them
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || restart) begin
         ramp  <= SAMPLE_W'(WORD_ZERO);
         phase <= 1'b0;
      end else if (load_out) begin
         ramp  <= ramp + SAMPLE_W'(RAMP_STEP);
         phase <= !phase; // see (RQ11)
      end
   end

   // One substitution stage per channel
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      pattern_mux #(
         .W (SAMPLE_W)
      ) u_mux (
         .i_enable   (diag_enable[c]),
         .i_sel      (diag_output_choice),
         .i_sample   (fifo_data[c*SAMPLE_W +: SAMPLE_W]),
         .i_word_one ({word_one_hi, word_one_lo}),
         .i_word_two ({word_two_hi, word_two_lo}),
         .i_ramp     (ramp),
         .i_phase    (phase),
         .o_data     (pat_word[c*SAMPLE_W +: SAMPLE_W])
      );
   end

   // Output register stage
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_out_valid <= 1'b0;
      end else if (fifo_ready) begin
         o_out_valid <= fifo_valid;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_out_ch_a <= '0;
         o_out_ch_b <= '0;
         o_out_ch_c <= '0;
         o_out_ch_d <= '0;
      end else if (load_out) begin
         o_out_ch_a <= pat_word[0*SAMPLE_W +: SAMPLE_W];
         o_out_ch_b <= pat_word[1*SAMPLE_W +: SAMPLE_W];
         o_out_ch_c <= pat_word[2*SAMPLE_W +: SAMPLE_W];
         o_out_ch_d <= pat_word[3*SAMPLE_W +: SAMPLE_W];
      end
   end
endmodule

/* verif/otp_properties.sv */
// Port-level assertions for the test-pattern block, bound to its top module
module otp_checker #(
   parameter int unsigned SAMPLE_W = 16
) (
   input wire logic                i_sys_clk,
   input wire logic                i_rst,
   input wire logic                i_spi_sen_n,
   input wire logic                o_spi_sdio_oe_n,
   input wire logic                i_in_valid,
   input wire logic                o_in_ready,
   input wire logic                o_out_valid,
   input wire logic                i_out_ready,
   input wire logic [SAMPLE_W-1:0] o_out_ch_a,
   input wire logic [SAMPLE_W-1:0] o_out_ch_d,
   input wire logic                o_mandatory_set_bit_a,
   input wire logic                o_mandatory_set_bit_b,
   input wire logic [diag_pkg::DDC_MSB:0] o_downconv_setting_pair_ab
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] idle_cnt;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // Cycles since the frame ended; the mode field and special bits may only change within a frame or just after it
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !i_spi_sen_n) begin
         idle_cnt <= 4'h0;
      end else if (idle_cnt != 4'hF) begin
         idle_cnt <= idle_cnt + 4'h1;
      end
   end
   reset_clear_a: assert property ($past(i_rst) |-> !o_out_valid && o_in_ready && !o_mandatory_set_bit_a
      && !o_mandatory_set_bit_b && o_downconv_setting_pair_ab == 4'h0) else $error("state not clear after reset");
   ddc_in_frame_a: assert property (!$past(i_rst) && $changed(o_downconv_setting_pair_ab) |-> idle_cnt < 4'h4)
      else $error("mode field changed outside a frame");
   mode_in_frame_a: assert property (!$past(i_rst) && $changed({o_mandatory_set_bit_a, o_mandatory_set_bit_b})
      |-> idle_cnt < 4'h4) else $error("special bits changed outside a frame");
   idle_release_a: assert property (i_spi_sen_n [*4] |-> o_spi_sdio_oe_n)
      else $error("data pin driven outside a frame");
   drive_in_frame_a: assert property ($fell(o_spi_sdio_oe_n) |-> !i_spi_sen_n && !$past(i_spi_sen_n, 2))
      else $error("data pin driven without a frame");
   out_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_ch_a)
      && $stable(o_out_ch_d)) else $error("stalled output sample changed");
   valid_drop_a: assert property (!$past(i_rst) && $fell(o_out_valid) |-> $past(i_out_ready))
      else $error("output valid dropped without acceptance");
   first_latency_a: assert property (!$past(i_rst) && $rose(o_out_valid) |-> $past(i_in_valid && o_in_ready, 2))
      else $error("output valid not two cycles after a push");
   full_hold_a: assert property (!o_in_ready && !(o_out_valid && i_out_ready) |=> !o_in_ready)
      else $error("full buffer accepted without a drain");
endmodule

bind output_test_pattern_control otp_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_sen_n(i_spi_sen_n), .o_spi_sdio_oe_n(o_spi_sdio_oe_n),
   .i_in_valid(i_in_valid), .o_in_ready(o_in_ready), .o_out_valid(o_out_valid), .i_out_ready(i_out_ready),
   .o_out_ch_a(o_out_ch_a), .o_out_ch_d(o_out_ch_d), .o_mandatory_set_bit_a(o_mandatory_set_bit_a),
   .o_mandatory_set_bit_b(o_mandatory_set_bit_b), .o_downconv_setting_pair_ab(o_downconv_setting_pair_ab));

/* verif/link_sink.sv */
// Downstream link receiver model taking four-channel words, with stall and slow modes
module link_sink #(
   parameter int unsigned W = 16
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   input  wire logic         i_stall,
   input  wire logic         i_slow,
   input  wire logic         i_valid,
   output logic              o_ready,
   input  wire logic [W-1:0] i_a,
   input  wire logic [W-1:0] i_b,
   input  wire logic [W-1:0] i_c,
   input  wire logic [W-1:0] i_d
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4*W-1:0] got[$];
   logic           beat;
   // Ready is registered like a real receiver, so stall requests land one cycle late
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_ready <= 1'b0;
         beat    <= 1'b0;
      end else begin
         beat    <= ~beat;
         o_ready <= !i_stall && (!i_slow || beat);
      end
   end
   // Every accepted word is queued for the bench to judge
   always @(posedge i_sys_clk) begin
      if (!i_rst && i_valid && o_ready) begin
         got.push_back({i_d, i_c, i_b, i_a});
      end
   end
endmodule

/* verif/tb.sv */
// Self-checking bench for the test-pattern register bank and its sample path
module tb
   import diag_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic             i_sys_clk, i_rst, sclk, sen_n, sdio_drv, sdio_out, sdio_oe_n;
   logic             in_valid, in_ready, out_valid, out_ready, stall, slow, page, spec_a, spec_b;
   logic [15:0]      in_a, in_b, in_c, in_d, out_a, out_b, out_c, out_d;
   logic [DDC_MSB:0] ddc;
   logic [63:0]      w;
   int               failures, num_checks;
   // Shared data wire: the device wins only while its enable is low
   wire logic sdio_wire = sdio_oe_n ? sdio_drv : sdio_out;
   localparam logic [15:0] W1 = 16'h1234, W2 = 16'hABCD;

   output_test_pattern_control u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_spi_sclk(sclk), .i_spi_sen_n(sen_n),
      .i_spi_sdio(sdio_wire), .o_spi_sdio(sdio_out), .o_spi_sdio_oe_n(sdio_oe_n), .i_in_valid(in_valid),
      .o_in_ready(in_ready), .i_in_ch_a(in_a), .i_in_ch_b(in_b), .i_in_ch_c(in_c), .i_in_ch_d(in_d),
      .o_out_valid(out_valid), .i_out_ready(out_ready), .o_out_ch_a(out_a), .o_out_ch_b(out_b),
      .o_out_ch_c(out_c), .o_out_ch_d(out_d), .o_digital_page_select(page), .o_mandatory_set_bit_a(spec_a),
      .o_mandatory_set_bit_b(spec_b), .o_downconv_setting_pair_ab(ddc));
   link_sink u_sink (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stall(stall), .i_slow(slow), .i_valid(out_valid),
      .o_ready(out_ready), .i_a(out_a), .i_b(out_b), .i_c(out_c), .i_d(out_d));

   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask

   task automatic report_and_stop();
      if (failures == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One 24-bit frame, MSB first; sclk phases of 6+ clocks keep the synchroniser happy
   task automatic spi(input logic rd, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rdat);
      logic [23:0] frame;
      frame = {rd, 7'h00, addr, wd};
      rdat = 8'h00;
      sen_n <= 1'b0;
      for (int i = 23; i >= 0; i--) begin
         tick(6);
         sdio_drv <= frame[i];
         tick(6);
         sclk <= 1'b1;
         if (i < 8) rdat[i] = sdio_wire;
         tick(6);
         sclk <= 1'b0;
      end
      tick(8);
      sen_n <= 1'b1;
      tick(6);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      spi(1'b0, a, d, r);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      spi(1'b1, a, 8'h00, r);
      cmp(r, e, "register readback");
   endtask

   // Offers one live word and returns on the edge that takes it
   task automatic push(input int n);
      in_valid <= 1'b1;
      in_a     <= 16'h1000 + 16'(n);
      in_b     <= 16'h2000 + 16'(n);
      in_c     <= 16'h3000 + 16'(n);
      in_d     <= 16'h4000 + 16'(n);
      for (int k = 0; k <= 200; k++) begin
         @(negedge i_sys_clk);
         if (in_ready === 1'b1) break;
         if (k == 200) begin
            failures++;
            $display("Error at %0t: input never accepted", $time);
            report_and_stop();
         end
      end
      @(posedge i_sys_clk);
   endtask

   task automatic wait_words(input int n);
      for (int k = 0; u_sink.got.size() < n; k++) begin
         if (k == 500) begin
            failures++;
            $display("Error at %0t: output words missing", $time);
            report_and_stop();
         end
         tick(1);
      end
   endtask

   function automatic logic [15:0] pat(input logic [3:0] code, input int n, input logic [15:0] live);
      case (code)
         PAT_ZEROS:  return 16'h0000;
         PAT_ONES:   return 16'hFFFF;
         PAT_TOGGLE: return n[0] ? 16'hAAAA : 16'h5555;
         PAT_RAMP:   return 16'(n);
         PAT_WORD1:  return W1;
         PAT_ALT:    return n[0] ? W2 : W1;
         PAT_DESKEW: return 16'hAAAA;
         default:    return live;
      endcase
   endfunction

   // Reset values, the page gate and an unmapped read
   task automatic t_reset();
      logic [7:0] regs [8] = '{8'h8D, 8'h8E, 8'h8F, 8'h90, 8'h91, 8'hAB, 8'hAC, 8'hAD};
      cmp({page, spec_a, spec_b, ddc}, 16'h0000, "ports after reset");
      wr(ADDR_WORD1_LO, 8'hFF);
      wr(ADDR_PAGE_SEL, 8'h01);
      cmp(page, 16'h0001, "page port");
      for (int i = 0; i < 8; i++) rchk(regs[i], 8'h00);
      rchk(8'h55, 8'h00);
   endtask

   // Every register written and read back with unused upper bits left zero, then eight codes through the mode field
   task automatic t_regs();
      logic [7:0] regs [8] = '{8'h8D, 8'h8E, 8'h8F, 8'h90, 8'h91, 8'hAB, 8'hAC, 8'hAD};
      logic [7:0] wv [8]   = '{8'h34, 8'h12, 8'hCD, 8'hAB, 8'hF0, 8'h01, 8'h01, 8'h08};
      logic [3:0] ddcs [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
      for (int i = 0; i < 8; i++) wr(regs[i], wv[i]);
      for (int i = 0; i < 8; i++) rchk(regs[i], wv[i]);
      cmp({spec_a, spec_b}, 16'h0003, "mode bit ports");
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_DDC_AB, {4'h0, ddcs[i]});
         cmp(ddc, ddcs[i], "mode field port");
      end
   endtask

   // Each selector code on channels A and C while B and D stay live; slow sink stalls
   task automatic t_patterns();
      logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8};
      slow <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_SEL_ENA, {codes[i], 4'b0101});
         u_sink.got.delete();
         for (int n = 0; n < 4; n++) push(n);
         in_valid <= 1'b0;
         wait_words(4);
         for (int n = 0; n < 4; n++) begin
            w = u_sink.got[n];
            cmp(w[15:0], pat(codes[i], n, 16'h1000 + 16'(n)), "channel A");
            cmp(w[31:16], 16'h2000 + 16'(n), "channel B live");
            cmp(w[47:32], pat(codes[i], n, 16'h3000 + 16'(n)), "channel C");
            cmp(w[63:48], 16'h4000 + 16'(n), "channel D live");
         end
      end
      slow <= 1'b0;
   endtask

   // Buffer filled against a stalled sink until it refuses, then drained in order
   task automatic t_fill();
      wr(ADDR_SEL_ENA, 8'h00);
      stall <= 1'b1;
      tick(3);
      u_sink.got.delete();
      for (int n = 0; n < 17; n++) push(n);
      tick(2);
      @(negedge i_sys_clk);
      cmp(in_ready, 16'h0000, "ready while full");
      @(posedge i_sys_clk);
      stall <= 1'b0;
      push(17);
      in_valid <= 1'b0;
      wait_words(18);
      for (int n = 0; n < 18; n++) begin
         w = u_sink.got[n];
         cmp(w[15:0], 16'h1000 + 16'(n), "drained word A");
         cmp(w[63:48], 16'h4000 + 16'(n), "drained word D");
      end
   endtask

   initial begin
      failures = 0;
      num_checks = 0;
      i_rst = 1'b1;
      {sclk, sdio_drv, in_valid, stall, slow} = 5'h00;
      sen_n = 1'b1;
      {in_a, in_b, in_c, in_d} = 64'h0;
      tick(6);
      i_rst <= 1'b0;
      tick(3);
      t_reset();
      t_regs();
      t_patterns();
      t_fill();
      report_and_stop();
   end
endmodule
